//--- core/ceeu_pkg.sv
package ceeu_pkg;

    // ------------------------------------------------------------
    // Mode field codes
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [4:0] MODE_SYS = 5'h1F;

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    localparam logic [31:0] VEC_RST  = 32'h0000_0000;
    localparam logic [31:0] VEC_UND  = 32'h0000_0004;
    localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
    localparam logic [31:0] VEC_PABT = 32'h0000_000C;
    localparam logic [31:0] VEC_DABT = 32'h0000_0010;
    localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ  = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ  = 32'h0000_001C;

    // ------------------------------------------------------------
    // Address offsets
    // ------------------------------------------------------------
    localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
    localparam logic [31:0] LINK_NEXT    = 32'h0000_0004;
    localparam logic [31:0] LINK_DABT    = 32'h0000_0008;
    localparam logic [31:0] RET_SUB_PABT = 32'h0000_0004;
    localparam logic [31:0] RET_SUB_DABT = 32'h0000_0008;

    // ------------------------------------------------------------
    // Banked link/saved-status slots
    // ------------------------------------------------------------
    localparam int         BANK_CNT = 5;
    localparam int         BANK_W   = 3;
    localparam logic [2:0] BANK_FIQ = 3'h0;
    localparam logic [2:0] BANK_IRQ = 3'h1;
    localparam logic [2:0] BANK_SVC = 3'h2;
    localparam logic [2:0] BANK_ABT = 3'h3;
    localparam logic [2:0] BANK_UND = 3'h4;

    // ------------------------------------------------------------
    // Timing, in processor cycles (clock period in ns, pipe depth in stages)
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SYNC_MAX    = 3;
    localparam int T_SYNC_MIN    = 2;
    localparam int T_LDM         = 20;
    localparam int T_EXC         = 3;
    localparam int T_FIQ         = 2;
    localparam int FIQ_LAT_MAX   = T_SYNC_MAX + T_LDM + T_EXC + T_FIQ;
    localparam int FIQ_LAT_MIN   = T_SYNC_MIN + T_FIQ;
    localparam int PIPE_DEPTH    = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  flags;
        logic [19:0] rsvd;
        logic        irq_mask;
        logic        fiq_mask;
        logic        compact;
        logic [4:0]  mode;
    } ceeu_status_t;

    localparam ceeu_status_t STATUS_RST = 32'h0000_00D3;

    typedef struct packed {
        logic [31:0]  link;
        ceeu_status_t saved;
    } ceeu_bank_t;

    typedef enum logic [2:0] {
        EXC_NONE, EXC_RST, EXC_DABT, EXC_FIQ, EXC_IRQ, EXC_PABT, EXC_UND, EXC_TRAP
    } ceeu_exc_t;

    typedef enum logic [1:0] {
        XFER_SINGLE, XFER_SWAP, XFER_MULTI
    } ceeu_xfer_t;

endpackage

//--- core/ceeu_bank_mem.sv
`timescale 1ns/100ps
module ceeu_bank_mem
    import ceeu_pkg::*;
#(
    parameter int DEPTH = BANK_CNT,
    parameter int AW    = BANK_W
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire ceeu_bank_t wr_data,
    input  wire logic [AW-1:0] rd_idx,
    output ceeu_bank_t      rd_data
);

    ceeu_bank_t mem_r [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en && (int'(wr_idx) < DEPTH))
            mem_r[wr_idx] <= wr_data;
    end

    // Registered read; out-of-range slots read as zero
    always_ff @(posedge clk)
    begin
        if (rst)
            rd_data <= '0;
        else if (int'(rd_idx) < DEPTH)
            rd_data <= mem_r[rd_idx];
        else
            rd_data <= '0;
    end

endmodule

//--- core/ceeu_exception_unit.sv
`timescale 1ns/100ps
// Functional notes
// - Abort input sampled only in fetch or data access cycles
// - Prefetch abort tags instruction; taken at pipeline head, dropped on flush
// - Aborted single load/store still writes back its base
// - Aborted swap leaves state as if never executed
// - Aborted multiple transfer runs to end, base writeback kept
// - After abort in multiple load, all later register writes suppressed
// - Link lets return minus 4 (prefetch) or 8 (data) retry
// - Software trap enters supervisor; return resumes after trap
// - Undefined instruction trap; return resumes after failing instruction
// - Vector table and entry mode per exception; 0x14 reserved
// - Priority: reset, data abort, fast, normal, prefetch, undef/trap
// - Data abort with fast interrupt: abort entry then fast entry
// - Worst fast latency within sync, longest load, abort and fast entry
// - After worst latency, executing at fast vector
// - Minimum request-to-handler latency is four cycles
// - Reset pin low: abandon instruction, fetch incrementing words
// - Reset release copies counter and status into supervisor bank
// - Then mode supervisor, both masks set, compact state cleared
// - Then fetch from zero in wide state
// - Mode field codes per processor mode
// - Entry saves link and status, forces mode, loads vector
// - Mask bits block normal and fast requests
module ceeu_exception_unit
    import ceeu_pkg::*;
#(
    parameter int TAG_DEPTH = PIPE_DEPTH
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         system_reset_low,
    input  wire logic         fast_int_request_low,
    input  wire logic         normal_int_request_low,
    input  wire logic         abort_in,
    input  wire logic         fetch_cycle,
    input  wire logic         data_cycle,
    input  wire ceeu_xfer_t   xfer_kind,
    input  wire logic         xfer_last,
    input  wire logic         pipe_advance,
    input  wire logic         head_exec,
    input  wire logic         head_undef,
    input  wire logic         head_trap,
    input  wire logic         branch_valid,
    input  wire logic [31:0]  branch_addr,
    input  wire logic         status_wr_en,
    input  wire ceeu_status_t status_wr_data,
    input  wire logic [2:0]   bank_rd_idx,
    output logic [31:0]       program_counter_reg,
    output logic [31:0]       fetch_addr,
    output ceeu_status_t      current_status_word,
    output logic              entry_busy,
    output logic              exc_taken,
    output ceeu_exc_t         exc_kind,
    output logic              base_wb_allow,
    output logic              reg_wr_block,
    output logic              swap_cancel,
    output ceeu_bank_t        bank_rd_data
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic ceeu_exc_t pick_exc(input logic dabt, input logic fiq,
                                           input logic irq, input logic pabt,
                                           input logic und, input logic trap);
        ceeu_exc_t e;
        e = EXC_NONE;
        if (dabt)
            e = EXC_DABT;
        else if (fiq)
            e = EXC_FIQ;
        else if (irq)
            e = EXC_IRQ;
        else if (pabt)
            e = EXC_PABT;
        else if (und)
            e = EXC_UND;
        else if (trap)
            e = EXC_TRAP;
        return e;
    endfunction

    function automatic logic [31:0] vec_of(input ceeu_exc_t e);
        logic [31:0] v;
        case (e)
            EXC_UND:  v = VEC_UND;
            EXC_TRAP: v = VEC_TRAP;
            EXC_PABT: v = VEC_PABT;
            EXC_DABT: v = VEC_DABT;
            EXC_IRQ:  v = VEC_IRQ;
            EXC_FIQ:  v = VEC_FIQ;
            default:  v = VEC_RST;
        endcase
        return v;
    endfunction

    function automatic logic [4:0] mode_of(input ceeu_exc_t e);
        logic [4:0] m;
        case (e)
            EXC_UND:  m = MODE_UND;
            EXC_PABT: m = MODE_ABT;
            EXC_DABT: m = MODE_ABT;
            EXC_IRQ:  m = MODE_IRQ;
            EXC_FIQ:  m = MODE_FIQ;
            default:  m = MODE_SVC;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] bank_of(input ceeu_exc_t e);
        logic [2:0] b;
        case (e)
            EXC_UND:  b = BANK_UND;
            EXC_PABT: b = BANK_ABT;
            EXC_DABT: b = BANK_ABT;
            EXC_IRQ:  b = BANK_IRQ;
            EXC_FIQ:  b = BANK_FIQ;
            default:  b = BANK_SVC;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN, ST_HOLD, ST_ENTRY, ST_RST_HOLD, ST_RST_SAVE, ST_RST_MODE, ST_RST_VEC
    } ceeu_state_t;

    ceeu_state_t            state_r;
    ceeu_status_t           status_r;
    ceeu_exc_t              exc_r;
    logic [31:0]            pc_r;
    logic [31:0]            fetch_r;
    logic [31:0]            last_exec_r;
    logic [31:0]            link_r;
    logic [TAG_DEPTH-1:0]   ptag_r;
    logic                   fiq_s1_r;
    logic                   fiq_s2_r;
    logic                   irq_s1_r;
    logic                   irq_s2_r;
    logic                   chain_r;
    logic                   lm_abort_r;
    logic                   taken_r;
    logic                   base_wb_r;
    logic                   swap_cancel_r;

    logic                   fiq_req;
    logic                   irq_req;
    logic                   boundary;
    logic                   abort_data;
    logic                   dabt_now;
    logic                   pabt_now;
    ceeu_exc_t              sel;
    logic                   take;
    logic                   bank_we;
    logic [2:0]             bank_widx;
    ceeu_bank_t             bank_wdata;

    // ------------------------------------------------------------
    // Request synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fiq_s1_r <= 1'b1;
            fiq_s2_r <= 1'b1;
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
        end
        else
        begin
            fiq_s1_r <= fast_int_request_low;
            fiq_s2_r <= fiq_s1_r;
            irq_s1_r <= normal_int_request_low;
            irq_s2_r <= irq_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Exception selection
    // ------------------------------------------------------------
    always_comb
    begin
        fiq_req    = !fiq_s2_r && !status_r.fiq_mask;
        irq_req    = !irq_s2_r && !status_r.irq_mask;
        // Chaining lets a fast request follow an abort entry at once
        boundary   = head_exec || chain_r;
        abort_data = data_cycle && abort_in;
        dabt_now   = (abort_data && (xfer_kind != XFER_MULTI))
                   || (xfer_last && (lm_abort_r || abort_data));
        pabt_now   = head_exec && ptag_r[TAG_DEPTH-1];
        sel        = pick_exc(dabt_now, boundary && fiq_req,
                              boundary && irq_req, pabt_now,
                              head_exec && head_undef,
                              head_exec && head_trap);
        take       = (state_r == ST_RUN) && (sel != EXC_NONE);
    end

    // ------------------------------------------------------------
    // Entry sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= ST_RUN;
            exc_r   <= EXC_NONE;
            link_r  <= '0;
            chain_r <= 1'b0;
            taken_r <= 1'b0;
        end
        else
        begin
            chain_r <= (state_r == ST_ENTRY);
            taken_r <= 1'b0;
            if (!system_reset_low)
            begin
                state_r <= ST_RST_HOLD;
                exc_r   <= EXC_RST;
            end
            else
            begin
                case (state_r)
                    ST_RUN:
                    begin
                        if (take)
                        begin
                            exc_r <= sel;
                            // Data abort link points 8 past the transfer
                            if (sel == EXC_DABT)
                                link_r <= last_exec_r + LINK_DABT;
                            else
                                link_r <= pc_r + LINK_NEXT;
                            // Data abort entry holds one extra cycle
                            state_r <= (sel == EXC_DABT) ? ST_HOLD : ST_ENTRY;
                        end
                    end
                    ST_HOLD:
                        state_r <= ST_ENTRY;
                    ST_ENTRY:
                    begin
                        state_r <= ST_RUN;
                        taken_r <= 1'b1;
                    end
                    ST_RST_HOLD:
                        state_r <= ST_RST_SAVE;
                    ST_RST_SAVE:
                        state_r <= ST_RST_MODE;
                    ST_RST_MODE:
                        state_r <= ST_RST_VEC;
                    ST_RST_VEC:
                    begin
                        state_r <= ST_RUN;
                        taken_r <= 1'b1;
                    end
                    default:
                        state_r <= ST_RUN;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            status_r <= STATUS_RST;
        else if (state_r == ST_RST_MODE)
        begin
            status_r.mode     <= MODE_SVC;
            status_r.irq_mask <= 1'b1;
            status_r.fiq_mask <= 1'b1;
            status_r.compact  <= 1'b0;
        end
        else if (state_r == ST_ENTRY)
        begin
            status_r.mode    <= mode_of(exc_r);
            status_r.compact <= 1'b0;
            if (exc_r == EXC_FIQ || exc_r == EXC_IRQ)
                status_r.irq_mask <= 1'b1;
            if (exc_r == EXC_FIQ)
                status_r.fiq_mask <= 1'b1;
        end
        else if (status_wr_en && system_reset_low)
            status_r <= status_wr_data;
    end

    // ------------------------------------------------------------
    // Program counter and fetch address
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pc_r        <= VEC_RST;
            fetch_r     <= VEC_RST;
            last_exec_r <= '0;
        end
        else if (!system_reset_low || state_r == ST_RST_HOLD)
            fetch_r <= fetch_r + WORD_STEP;
        else if (state_r == ST_RST_VEC)
        begin
            pc_r    <= VEC_RST;
            fetch_r <= VEC_RST;
        end
        else if (state_r == ST_ENTRY)
        begin
            pc_r    <= vec_of(exc_r);
            fetch_r <= vec_of(exc_r);
        end
        else if (state_r == ST_RUN)
        begin
            if (branch_valid && !take)
            begin
                pc_r    <= branch_addr;
                fetch_r <= branch_addr;
            end
            else
            begin
                if (head_exec && !take)
                begin
                    pc_r        <= pc_r + WORD_STEP;
                    last_exec_r <= pc_r;
                end
                if (fetch_cycle)
                    fetch_r <= fetch_r + WORD_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // Prefetch abort tags
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || !system_reset_low || branch_valid || state_r != ST_RUN)
            ptag_r <= '0;
        else
        begin
            if (pipe_advance)
                ptag_r <= {ptag_r[TAG_DEPTH-2:0], fetch_cycle && abort_in};
            else
            begin
                if (head_exec)
                    ptag_r[TAG_DEPTH-1] <= 1'b0;
                if (fetch_cycle && abort_in)
                    ptag_r[0] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Data abort effects on transfers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || !system_reset_low)
        begin
            lm_abort_r    <= 1'b0;
            base_wb_r     <= 1'b0;
            swap_cancel_r <= 1'b0;
        end
        else
        begin
            // Later loads of the block, incl. base and counter, are blocked
            if (abort_data && xfer_kind == XFER_MULTI && !xfer_last)
                lm_abort_r <= 1'b1;
            else if (xfer_last)
                lm_abort_r <= 1'b0;
            base_wb_r     <= abort_data && (xfer_kind != XFER_SWAP);
            swap_cancel_r <= abort_data && (xfer_kind == XFER_SWAP);
        end
    end

    // ------------------------------------------------------------
    // Banked link and saved status
    // ------------------------------------------------------------
    always_comb
    begin
        bank_we    = 1'b0;
        bank_widx  = BANK_SVC;
        bank_wdata = '{link: pc_r, saved: status_r};
        if (state_r == ST_RST_SAVE)
            bank_we = 1'b1;
        else if (state_r == ST_ENTRY)
        begin
            bank_we    = 1'b1;
            bank_widx  = bank_of(exc_r);
            bank_wdata = '{link: link_r, saved: status_r};
        end
    end

    ceeu_bank_mem #(
        .DEPTH (BANK_CNT),
        .AW    (BANK_W)
    ) u_bank (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (bank_we),
        .wr_idx  (bank_widx),
        .wr_data (bank_wdata),
        .rd_idx  (bank_rd_idx),
        .rd_data (bank_rd_data)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign program_counter_reg = pc_r;
    assign fetch_addr          = fetch_r;
    assign current_status_word = status_r;
    assign exc_taken           = taken_r;
    assign exc_kind            = exc_r;
    assign base_wb_allow       = base_wb_r;
    assign reg_wr_block        = lm_abort_r;
    assign swap_cancel         = swap_cancel_r;

    always_ff @(posedge clk)
    begin
        if (rst)
            entry_busy <= 1'b0;
        else
            entry_busy <= !system_reset_low || take
                        || (state_r == ST_HOLD) || (state_r > ST_ENTRY && state_r != ST_RST_VEC);
    end

endmodule

//--- testbench/ceeu_exception_unit_asserts.sv
`timescale 1ns/100ps
module ceeu_exception_unit_asserts
    import ceeu_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         system_reset_low,
    input wire logic         fast_int_request_low,
    input wire logic         abort_in,
    input wire logic         data_cycle,
    input wire ceeu_xfer_t   xfer_kind,
    input wire logic         xfer_last,
    input wire logic         entry_busy,
    input wire logic [31:0]  program_counter_reg,
    input wire logic [31:0]  fetch_addr,
    input wire ceeu_status_t current_status_word,
    input wire logic         exc_taken,
    input wire ceeu_exc_t    exc_kind,
    input wire logic         base_wb_allow,
    input wire logic         reg_wr_block,
    input wire logic         swap_cancel
);
    localparam int LAT = FIQ_LAT_MAX;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_hold;
        !system_reset_low ##1 !system_reset_low ##1 !system_reset_low;
    endsequence
    sequence s_dab;
        data_cycle && abort_in && !entry_busy && system_reset_low;
    endsequence
    property p_hold;
        s_hold |-> fetch_addr == $past(fetch_addr) + WORD_STEP;
    endproperty
    property p_rel;
        $rose(system_reset_low) |-> ##[1:6] (exc_taken && program_counter_reg == VEC_RST
            && current_status_word[7:0] == 8'hD3);
    endproperty
    property p_lat;
        $fell(fast_int_request_low) && !current_status_word.fiq_mask && !entry_busy
            |-> ##[1:LAT] program_counter_reg == VEC_FIQ;
    endproperty
    property p_min;
        $fell(fast_int_request_low) && program_counter_reg != VEC_FIQ
            |-> (program_counter_reg != VEC_FIQ)[*4];
    endproperty
    property p_fiq;
        exc_taken && exc_kind == EXC_FIQ |-> current_status_word.mode == MODE_FIQ
            && current_status_word.fiq_mask && current_status_word.irq_mask;
    endproperty
    property p_irq;
        exc_taken && exc_kind == EXC_IRQ |-> current_status_word.mode == MODE_IRQ
            && current_status_word.irq_mask && program_counter_reg == VEC_IRQ;
    endproperty
    property p_swap;
        s_dab and xfer_kind == XFER_SWAP |=> swap_cancel && !base_wb_allow;
    endproperty
    property p_base;
        s_dab and xfer_kind != XFER_SWAP |=> base_wb_allow;
    endproperty
    property p_blk;
        s_dab and xfer_kind == XFER_MULTI && !xfer_last |=> reg_wr_block;
    endproperty
    property p_noab;
        !data_cycle |=> !base_wb_allow && !swap_cancel;
    endproperty
    a_hold: assert property (p_hold) else $error("fetch address not stepping");
    a_rel: assert property (p_rel) else $error("bad reset release");
    a_lat: assert property (p_lat) else $error("fast entry too late");
    a_min: assert property (p_min) else $error("fast entry too early");
    a_fiq: assert property (p_fiq) else $error("bad fast entry state");
    a_irq: assert property (p_irq) else $error("bad normal entry state");
    a_swap: assert property (p_swap) else $error("swap not cancelled");
    a_base: assert property (p_base) else $error("base writeback missing");
    a_blk: assert property (p_blk) else $error("register writes not blocked");
    a_noab: assert property (p_noab) else $error("abort outside access");
endmodule
bind ceeu_exception_unit ceeu_exception_unit_asserts chk_i (.*);

//--- testbench/ceeu_mmu_model.sv
`timescale 1ns/100ps
module ceeu_mmu_model
(
    input  wire logic fetch_cycle,
    input  wire logic data_cycle,
    input  wire logic fault_fetch,
    input  wire logic fault_data,
    output logic      abort_in
);
    // Abort raised in the very access cycle it refuses
    assign abort_in = (fetch_cycle && fault_fetch) || (data_cycle && fault_data);
endmodule

//--- testbench/test_cpu_exception_entry_unit.sv
`timescale 1ns/100ps
module test_cpu_exception_entry_unit
    import ceeu_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, system_reset_low = 1'b1, fast_int_request_low = 1'b1;
    logic normal_int_request_low = 1'b1, fetch_cycle = 1'b0, data_cycle = 1'b0;
    logic xfer_last = 1'b0, pipe_advance = 1'b0, head_exec = 1'b0, head_undef = 1'b0;
    logic head_trap = 1'b0, branch_valid = 1'b0, status_wr_en = 1'b0;
    logic fault_fetch = 1'b0, fault_data = 1'b0;
    logic abort_in, entry_busy, exc_taken, base_wb_allow, reg_wr_block, swap_cancel;
    logic [31:0] branch_addr = 32'h0000_0040;
    logic [31:0] program_counter_reg, fetch_addr;
    logic [2:0] bank_rd_idx = 3'h0;
    ceeu_xfer_t xfer_kind = XFER_SINGLE;
    ceeu_status_t status_wr_data = 32'h0000_0010, current_status_word;
    ceeu_exc_t exc_kind;
    ceeu_bank_t bank_rd_data;
    int error_cnt = 0, checked = 0, k;
    always #50 clk = ~clk;
    ceeu_exception_unit uut (.*);
    ceeu_mmu_model mmu (.*);
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One-cycle stimuli are dropped at the first edge, then the head keeps executing
    task go(input logic [31:0] vec, input logic [4:0] mode);
        int i;
        @(posedge clk);
        {head_undef, head_trap, fetch_cycle, data_cycle, fault_fetch, fault_data} <= '0;
        {head_exec, pipe_advance} <= 2'b11;
        for (i = 0; i < 40 && exc_taken !== 1'b1; i++)
            @(posedge clk);
        if (i == 40)
        begin
            error_cnt++;
            end_of_test();
        end
        chk(program_counter_reg, vec);
        chk(current_status_word.mode, mode);
    endtask
    task setst(input logic [31:0] v);
        status_wr_en <= 1'b1;
        status_wr_data <= v;
        cyc(1);
        status_wr_en <= 1'b0;
        cyc(1);
    endtask
    task rd(input logic [2:0] idx, input logic [31:0] exp, input logic lnk);
        bank_rd_idx <= idx;
        cyc(2);
        chk(lnk ? bank_rd_data.link : bank_rd_data.saved, exp);
    endtask
    task quiet(input int n);
        int c;
        c = 0;
        repeat (n)
        begin
            @(posedge clk);
            c += (exc_taken === 1'b1);
        end
        chk(c, 0);
    endtask
    initial
    begin
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        chk(current_status_word, STATUS_RST);
        chk(program_counter_reg, VEC_RST);
        system_reset_low <= 1'b0;
        cyc(5);
        system_reset_low <= 1'b1;
        go(VEC_RST, MODE_SVC);
        chk(exc_kind, EXC_RST);
        setst(32'h10);
        fast_int_request_low <= 1'b0;
        go(VEC_FIQ, MODE_FIQ);
        rd(BANK_FIQ, 32'h10, 1'b0);
        quiet(30);
        fast_int_request_low <= 1'b1;
        // Let the released pin clear both sync stages before unmasking
        cyc(3);
        setst(32'h10);
        normal_int_request_low <= 1'b0;
        go(VEC_IRQ, MODE_IRQ);
        normal_int_request_low <= 1'b1;
        rd(BANK_IRQ, 32'h10, 1'b0);
        for (k = 0; k < 2; k++)
        begin
            setst(32'h10);
            head_undef <= (k == 0);
            head_trap <= (k == 1);
            go(k ? VEC_TRAP : VEC_UND, k ? MODE_SVC : MODE_UND);
            rd(k ? BANK_SVC : BANK_UND, 32'h10, 1'b0);
        end
        setst(32'h10);
        {head_exec, pipe_advance, fetch_cycle, fault_fetch} <= 4'b0011;
        cyc(1);
        {fetch_cycle, fault_fetch, branch_valid} <= 3'b001;
        cyc(1);
        {head_exec, pipe_advance, branch_valid} <= 3'b110;
        quiet(10);
        {fetch_cycle, fault_fetch} <= 2'b11;
        go(VEC_PABT, MODE_ABT);
        for (k = 0; k < 2; k++)
        begin
            setst(32'h10);
            {data_cycle, fault_data, xfer_last} <= 3'b111;
            xfer_kind <= k ? XFER_SWAP : XFER_SINGLE;
            go(VEC_DABT, MODE_ABT);
        end
        setst(32'h10);
        {data_cycle, fault_data, xfer_last} <= 3'b110;
        xfer_kind <= XFER_MULTI;
        cyc(1);
        fault_data <= 1'b0;
        cyc(1);
        chk(reg_wr_block, 1'b1);
        xfer_last <= 1'b1;
        go(VEC_DABT, MODE_ABT);
        setst(32'h10);
        {data_cycle, fault_data, xfer_last, fast_int_request_low} <= 4'b1110;
        xfer_kind <= XFER_SINGLE;
        // Head keeps executing, so catch each entry as it is taken
        go(VEC_DABT, MODE_ABT);
        go(VEC_FIQ, MODE_FIQ);
        rd(BANK_FIQ, VEC_DABT + LINK_NEXT, 1'b1);
        end_of_test();
    end
endmodule
